// ===== hdl/sample_clock_generation.sv
// Sample clock generator: AXI4-Lite registers and rate calculation
`timescale 1ns/1ps
`include "clkgen_defs.svh"
module sample_clock_generation
#(
    parameter bit          FAST   = 1'b0,
    parameter int unsigned NUM_CH = 4
)
(
    input  wire  logic              aclk,
    input  wire  logic              aresetn,
    input  wire  clkgen_pkg::addr_t awaddr,
    input  wire  logic              awvalid,
    output logic                    awready,
    input  wire  clkgen_pkg::data_t wdata,
    input  wire  logic [3:0]        wstrb,
    input  wire  logic              wvalid,
    output logic                    wready,
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire  logic              bready,
    input  wire  clkgen_pkg::addr_t araddr,
    input  wire  logic              arvalid,
    output logic                    arready,
    output clkgen_pkg::data_t       rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire  logic              rready,
    output logic                    pll_enable,
    output logic                    ref_external,
    output clkgen_pkg::data_t       pll_ref_div,
    output clkgen_pkg::data_t       pll_mult,
    output logic [11:0]             quartz_div,
    output logic                    clock_out_drive,
    output logic                    term_connect,
    output logic                    rate_busy
);
    import clkgen_pkg::*;

    // Quartz runs at the top rate, so divisor one gives it
    localparam data_t MAX_RATE = FAST ? `CG_RATE_FAST : `CG_RATE_SLOW;

    if (NUM_CH != 1 && NUM_CH != 2 && NUM_CH != 4)
    begin : g_bad_ch
        $error("NUM_CH must be 1, 2 or 4");
    end

    calc_state_t state_reg;
    logic        aw_got_reg;
    logic        w_got_reg;
    addr_t       aw_addr_reg;
    data_t       w_data_reg;
    logic [3:0]  w_strb_reg;
    data_t       rate_reg;
    logic        pll_reg;
    logic        clkout_reg;
    logic        term_reg;
    data_t       ref_reg;
    logic [3:0]  chan_reg;
    logic        calc_req_reg;
    data_t       tgt_reg;
    data_t       ach_reg;
    data_t       pfd_reg;
    data_t       mult_reg;
    data_t       div_a_reg;
    data_t       div_b_reg;
    logic        div_go_reg;
    logic        launched_reg;
    logic [5:0]  div_cnt_reg;
    data_t       rem_reg;
    data_t       quo_reg;
    logic [4:0]  idx_reg;
    data_t       best_err_reg;
    data_t       best_rate_reg;
    logic [11:0] best_div_reg;
    logic [14:0] wr_idx;
    logic        wr_fire;
    logic        wr_map;
    data_t       wr_val;
    data_t       rd_val;
    logic        rd_map;
    logic        div_idle;
    data_t       ref_hz;
    logic [33:0] trial;
    data_t       prod;
    data_t       err;

    // Divisors allowed while the PLL is bypassed
    function automatic logic [11:0] div_val(input logic [4:0] i);
        case (i)
            5'h00: div_val = 12'h001;
            5'h01: div_val = 12'h002;
            5'h02: div_val = 12'h004;
            5'h03: div_val = 12'h008;
            5'h04: div_val = 12'h00A;
            5'h05: div_val = 12'h010;
            5'h06: div_val = 12'h014;
            5'h07: div_val = 12'h028;
            5'h08: div_val = 12'h032;
            5'h09: div_val = 12'h050;
            5'h0A: div_val = 12'h064;
            5'h0B: div_val = 12'h0C8;
            5'h0C: div_val = 12'h190;
            5'h0D: div_val = 12'h1F4;
            5'h0E: div_val = 12'h320;
            5'h0F: div_val = 12'h3E8;
            default: div_val = 12'h7D0;
        endcase
    endfunction

    // Channel sets that the fitted channel count can serve
    function automatic logic chan_ok(input logic [3:0] c);
        case (c)
            4'h1: chan_ok = 1'b1;
            4'h3: chan_ok = (NUM_CH >= 2);
            4'h5: chan_ok = (NUM_CH == 4);
            4'hF: chan_ok = (NUM_CH == 4);
            default: chan_ok = 1'b0;
        endcase
    endfunction

    function automatic data_t merge(input data_t o, input data_t d,
                                    input logic [3:0] s);
        merge = o;
        for (int b = 0; b < 4; b++)
        begin
            if (s[b])
                merge[b*8 +: 8] = d[b*8 +: 8];
        end
    endfunction

    function automatic data_t clamp(input data_t v, input data_t lo,
                                    input data_t hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    //----------------------------------------------------------------
    // Register bus
    //----------------------------------------------------------------
    assign wr_fire = aw_got_reg && w_got_reg && !bvalid;
    assign wr_idx  = aw_addr_reg[16:2];
    assign wr_val  = merge(32'h0, w_data_reg, w_strb_reg);
    assign wr_map  = (wr_idx == `CG_IDX_RATE) || (wr_idx == `CG_IDX_PLL)
                  || (wr_idx == `CG_IDX_CLKOUT) || (wr_idx == `CG_IDX_TERM)
                  || (wr_idx == `CG_IDX_REF) || (wr_idx == `CG_IDX_CHAN)
                  || (wr_idx == `CG_IDX_STAT);

    // Write address and data may come in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_reg  <= 1'b0;
            w_got_reg   <= 1'b0;
            awready     <= 1'b0;
            wready      <= 1'b0;
            bvalid      <= 1'b0;
            bresp       <= `CG_RESP_OKAY;
            aw_addr_reg <= 17'h00000;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_got_reg  <= 1'b1;
                aw_addr_reg <= awaddr;
                awready     <= 1'b0;
            end
            else if (!aw_got_reg && !bvalid)
                awready <= 1'b1;
            if (wvalid && wready)
            begin
                w_got_reg  <= 1'b1;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
                wready     <= 1'b0;
            end
            else if (!w_got_reg && !bvalid)
                wready <= 1'b1;
            if (wr_fire)
            begin
                bvalid     <= 1'b1;
                bresp      <= wr_map ? `CG_RESP_OKAY : `CG_RESP_SLVERR;
                aw_got_reg <= 1'b0;
                w_got_reg  <= 1'b0;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    // Read decode; the rate index returns the achieved rate
    always_comb
    begin
        rd_map = 1'b1;
        rd_val = 32'h00000000;
        if (araddr[16:2] == `CG_IDX_RATE)
            rd_val = ach_reg;
        else if (araddr[16:2] == `CG_IDX_PLL)
            rd_val = {31'h0, pll_reg};
        else if (araddr[16:2] == `CG_IDX_CLKOUT)
            rd_val = {31'h0, clkout_reg};
        else if (araddr[16:2] == `CG_IDX_TERM)
            rd_val = {31'h0, term_reg};
        else if (araddr[16:2] == `CG_IDX_REF)
            rd_val = ref_reg;
        else if (araddr[16:2] == `CG_IDX_CHAN)
            rd_val = {28'h0, chan_reg};
        else if (araddr[16:2] == `CG_IDX_STAT)
            rd_val[`CG_STAT_BUSY] = rate_busy;
        else
            rd_map = 1'b0;
    end

    // One read at a time; answer one cycle after the address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= `CG_RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_val;
            rresp   <= rd_map ? `CG_RESP_OKAY : `CG_RESP_SLVERR;
        end
        else if (rvalid && rready)
            rvalid <= 1'b0;
        else if (!rvalid)
            arready <= 1'b1;
    end

    //----------------------------------------------------------------
    // Settings
    //----------------------------------------------------------------
    // Illegal channel sets are dropped so the stored set stays legal
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rate_reg   <= `CG_RST_RATE;
            pll_reg    <= 1'b1;
            clkout_reg <= 1'b0;
            term_reg   <= 1'b0;
            ref_reg    <= 32'h00000000;
            chan_reg   <= `CG_RST_CHAN;
        end
        else if (wr_fire)
        begin
            if (wr_idx == `CG_IDX_RATE)
                rate_reg <= merge(rate_reg, w_data_reg, w_strb_reg);
            else if (wr_idx == `CG_IDX_PLL)
                pll_reg <= wr_val[0];
            else if (wr_idx == `CG_IDX_CLKOUT)
                clkout_reg <= wr_val[0];
            else if (wr_idx == `CG_IDX_TERM)
                term_reg <= wr_val[0];
            else if (wr_idx == `CG_IDX_REF)
                ref_reg <= (merge(ref_reg, w_data_reg, w_strb_reg) == 0)
                    ? 32'h00000000
                    : clamp(merge(ref_reg, w_data_reg, w_strb_reg),
                            `CG_REF_MIN, `CG_REF_MAX);
            else if (wr_idx == `CG_IDX_CHAN && chan_ok(wr_val[3:0]))
                chan_reg <= wr_val[3:0];
        end
    end

    // Rate, PLL, reference and channel writes rerun the calculation; a set beats the clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            calc_req_reg <= 1'b1;
        else if (wr_fire && wr_map && wr_idx != `CG_IDX_CLKOUT
                 && wr_idx != `CG_IDX_TERM && wr_idx != `CG_IDX_STAT)
            calc_req_reg <= 1'b1;
        else if (state_reg == ST_IDLE)
            calc_req_reg <= 1'b0;
    end

    // Connector is an output only with internal reference
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            clock_out_drive <= 1'b0;
            term_connect    <= 1'b0;
            ref_external    <= 1'b0;
        end
        else
        begin
            clock_out_drive <= clkout_reg && (ref_reg == 0);
            term_connect    <= term_reg
                && !(clkout_reg && (ref_reg == 0));
            ref_external    <= (ref_reg != 0);
        end
    end
    assign pll_enable = pll_reg;

    //----------------------------------------------------------------
    // Serial divider, 32 cycles per quotient
    //----------------------------------------------------------------
    assign trial    = {1'b0, rem_reg, quo_reg[31]} - {2'b00, div_b_reg};
    assign div_idle = (div_cnt_reg == 6'h00) && !div_go_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_cnt_reg <= 6'h00;
            rem_reg     <= 32'h00000000;
            quo_reg     <= 32'h00000000;
        end
        else if (div_go_reg)
        begin
            div_cnt_reg <= 6'h20;
            rem_reg     <= 32'h00000000;
            quo_reg     <= div_a_reg;
        end
        else if (div_cnt_reg != 6'h00)
        begin
            div_cnt_reg <= div_cnt_reg - 6'h01;
            quo_reg     <= {quo_reg[30:0], !trial[33]};
            rem_reg     <= trial[33] ? {rem_reg[30:0], quo_reg[31]}
                                     : trial[31:0];
        end
    end

    //----------------------------------------------------------------
    // Rate calculation
    //----------------------------------------------------------------
    assign ref_hz = (ref_reg == 0) ? `CG_INT_REF : ref_reg;
    assign prod   = 32'(mult_reg * pfd_reg);
    assign err    = (quo_reg > tgt_reg) ? quo_reg - tgt_reg
                                        : tgt_reg - quo_reg;

    // PLL: ref divider, comparison rate, multiplier, range fix-up.
    // Divider mode walks every divisor of the div_val table, one division each.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg     <= ST_IDLE;
            div_go_reg    <= 1'b0;
            launched_reg  <= 1'b0;
            div_a_reg     <= 32'h00000000;
            div_b_reg     <= 32'h00000001;
            tgt_reg       <= 32'h00000000;
            ach_reg       <= `CG_MIN_RATE;
            pfd_reg       <= 32'h00000001;
            mult_reg      <= 32'h00000001;
            pll_ref_div   <= 32'h00000001;
            pll_mult      <= 32'h00000001;
            quartz_div    <= 12'h001;
            idx_reg       <= 5'h00;
            best_err_reg  <= 32'hFFFFFFFF;
            best_rate_reg <= 32'h00000000;
            best_div_reg  <= 12'h001;
            rate_busy     <= 1'b0;
        end
        else
        begin
            div_go_reg <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    rate_busy <= calc_req_reg;
                    if (calc_req_reg)
                    begin
                        tgt_reg <= clamp(rate_reg, `CG_MIN_RATE,
                                         MAX_RATE);
                        idx_reg      <= 5'h00;
                        best_err_reg <= 32'hFFFFFFFF;
                        launched_reg <= 1'b0;
                        state_reg    <= pll_reg ? ST_DIV_REF : ST_QUARTZ;
                    end
                end
                ST_DIV_REF:
                begin
                    if (!launched_reg)
                    begin
                        div_a_reg    <= ref_hz;
                        div_b_reg    <= `CG_PLL_STEP;
                        div_go_reg   <= 1'b1;
                        launched_reg <= 1'b1;
                    end
                    else if (div_idle)
                    begin
                        div_b_reg    <= (quo_reg == 0) ? 32'h1 : quo_reg;
                        pll_ref_div  <= (quo_reg == 0) ? 32'h1 : quo_reg;
                        launched_reg <= 1'b0;
                        state_reg    <= ST_DIV_PFD;
                    end
                end
                ST_DIV_PFD:
                begin
                    if (!launched_reg)
                    begin
                        div_a_reg    <= ref_hz;
                        div_go_reg   <= 1'b1;
                        launched_reg <= 1'b1;
                    end
                    else if (div_idle)
                    begin
                        pfd_reg      <= quo_reg;
                        launched_reg <= 1'b0;
                        state_reg    <= ST_DIV_MUL;
                    end
                end
                ST_DIV_MUL:
                begin
                    if (!launched_reg)
                    begin
                        div_a_reg    <= tgt_reg + {1'b0, pfd_reg[31:1]};
                        div_b_reg    <= pfd_reg;
                        div_go_reg   <= 1'b1;
                        launched_reg <= 1'b1;
                    end
                    else if (div_idle)
                    begin
                        mult_reg     <= (quo_reg == 0) ? 32'h1 : quo_reg;
                        launched_reg <= 1'b0;
                        state_reg    <= ST_FIX;
                    end
                end
                ST_FIX:
                begin
                    // Step the multiplier back inside the rate limits
                    if (prod > MAX_RATE && mult_reg > 1)
                        mult_reg <= mult_reg - 32'h1;
                    else if (prod < `CG_MIN_RATE)
                        mult_reg <= mult_reg + 32'h1;
                    else
                    begin
                        ach_reg   <= prod;
                        pll_mult  <= mult_reg;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_QUARTZ:
                begin
                    if (!launched_reg)
                    begin
                        div_a_reg    <= MAX_RATE;
                        div_b_reg    <= {20'h0, div_val(idx_reg)};
                        div_go_reg   <= 1'b1;
                        launched_reg <= 1'b1;
                    end
                    else if (div_idle)
                    begin
                        launched_reg <= 1'b0;
                        idx_reg      <= idx_reg + 5'h01;
                        if (err < best_err_reg)
                        begin
                            best_err_reg  <= err;
                            best_rate_reg <= quo_reg;
                            best_div_reg  <= div_val(idx_reg);
                        end
                        if (idx_reg == `CG_LAST_DIV)
                        begin
                            // Last quotient may still be the winner
                            ach_reg <= (err < best_err_reg)
                                ? quo_reg : best_rate_reg;
                            quartz_div <= (err < best_err_reg)
                                ? div_val(idx_reg) : best_div_reg;
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    //----------------------------------------------------------------
    // Checks
    //----------------------------------------------------------------
    a_term_needs_input: assert property (@(posedge aclk)
        disable iff (!aresetn) term_connect |-> !clock_out_drive)
        else $error("termination on while clock drives out");

    a_term_off_open: assert property (@(posedge aclk)
        disable iff (!aresetn) !term_reg ##1 !term_reg |-> !term_connect)
        else $error("termination on while disabled");

    a_clkout_internal: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (clkout_reg && ref_reg == 0) [*2] |-> clock_out_drive)
        else $error("clock output missing with internal clocking");

    a_rate_floor: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ach_reg >= `CG_MIN_RATE && ach_reg <= MAX_RATE)
        else $error("achieved rate outside limits");

    a_chan_legal: assert property (@(posedge aclk)
        disable iff (!aresetn) chan_ok(chan_reg))
        else $error("illegal channel set stored");

    a_quartz_rate: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (state_reg == ST_IDLE && !calc_req_reg && !pll_reg
         && $past(state_reg) == ST_QUARTZ)
        |-> ach_reg == MAX_RATE / {20'h0, quartz_div})
        else $error("divider rate does not match divisor");

    a_pll_product: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ($past(state_reg) == ST_FIX && state_reg == ST_IDLE)
        |-> ach_reg == 32'(pll_mult * pfd_reg))
        else $error("PLL rate does not match settings");

    a_calc_bounded: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $rose(rate_busy) |-> ##[1:800] (!rate_busy || calc_req_reg))
        else $error("rate calculation does not finish");

    a_read_rate: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (arvalid && arready && araddr[16:2] == `CG_IDX_RATE)
        |=> rdata == $past(ach_reg))
        else $error("rate read is not the achieved rate");

    a_pll_default: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $rose(aresetn) |-> pll_reg)
        else $error("PLL select not set after reset");
endmodule

// ===== hdl/clkgen_defs.svh
// Offsets, reset values and limits of the sample clock generator
`ifndef CLKGEN_DEFS_SVH
`define CLKGEN_DEFS_SVH

// Register indices and the status busy bit; byte address is four times the index
`define CG_IDX_RATE    15'd20000
`define CG_IDX_PLL     15'd20030
`define CG_IDX_CLKOUT  15'd20110
`define CG_IDX_TERM    15'd20120
`define CG_IDX_REF     15'd20140
`define CG_IDX_CHAN    15'd20200
`define CG_IDX_STAT    15'd20210
`define CG_STAT_BUSY   0

// Reset values
`define CG_RST_RATE    32'h000F4240
`define CG_RST_CHAN    4'h1

// Frequencies in hertz; last divisor table index
`define CG_MIN_RATE    32'h000003E8
`define CG_INT_REF     32'h02625A00
`define CG_REF_MIN     32'h000F4240
`define CG_REF_MAX     32'h07735940
`define CG_PLL_STEP    32'h000003E8
`define CG_RATE_SLOW   32'h01312D00
`define CG_RATE_FAST   32'h02FAF080
`define CG_LAST_DIV    5'h10

// Bus answers
`define CG_RESP_OKAY   2'h0
`define CG_RESP_SLVERR 2'h2

`endif

// ===== hdl/clkgen_pkg.sv
// Types shared by the sample clock generator
package clkgen_pkg;
    typedef logic [16:0] addr_t;
    typedef logic [31:0] data_t;
    // Gray codes along the PLL calculation path from ST_IDLE to ST_FIX
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_DIV_REF = 3'h1,
        ST_DIV_PFD = 3'h3,
        ST_DIV_MUL = 3'h2,
        ST_FIX     = 3'h6,
        ST_QUARTZ  = 3'h7
    } calc_state_t;
endpackage

// ===== bench/ext_ref_source.sv
// External reference generator seen on the clock connector
`timescale 1ns/1ps
module ext_ref_source
#(
    parameter int unsigned REF_HZ = 10000000
)
(
    output logic [31:0] ref_hz
);
    // Nominal frequency that the host must program exactly
    assign ref_hz = REF_HZ;
endmodule

// ===== bench/sample_clock_generation_test.sv
// Register-level test of the sample clock generator
`timescale 1ns/1ps
module sample_clock_generation_test;
    import clkgen_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic pll_enable, ref_external, clock_out_drive, term_connect, rate_busy;
    addr_t awaddr = '0, araddr = '0;
    data_t wdata = '0, rdata, pll_ref_div, pll_mult, ref_hz, v;
    logic [1:0] bresp, rresp, r;
    logic [11:0] quartz_div;
    int fails = 0, cmp_count = 0;
    // Clock at 20 MHz
    always #25 aclk = ~aclk;
    sample_clock_generation i_dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .pll_enable(pll_enable),
        .ref_external(ref_external), .pll_ref_div(pll_ref_div),
        .pll_mult(pll_mult), .quartz_div(quartz_div),
        .clock_out_drive(clock_out_drive), .term_connect(term_connect),
        .rate_busy(rate_busy));
    ext_ref_source i_ref (.ref_hz(ref_hz));
    task automatic chk(input string n, input data_t e, input data_t g);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    // Write one word; hold each channel until its own ready
    task automatic wr(input int i, input data_t d);
        @(posedge aclk);
        awaddr <= 17'(i * 4); wdata <= d; awvalid <= 1; wvalid <= 1;
        bready <= 1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end
        while (bvalid !== 1'b1);
        r = bresp; bready <= 0;
        // Let the calculation start, then wait for rate_busy to fall; only the watchdog limits this wait
        repeat (3) @(posedge aclk);
        while (rate_busy !== 1'b0) @(posedge aclk);
    endtask
    // Read one word; the answer is taken at the edge it is seen
    task automatic rd(input int i);
        @(posedge aclk);
        araddr <= 17'(i * 4); arvalid <= 1; rready <= 1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 0;
        end
        while (rvalid !== 1'b1);
        v = rdata; r = rresp; rready <= 0;
    endtask
    // Defaults after reset: PLL on the internal reference
    task automatic t_defaults;
        rd(20030); chk("pll_select", 1, v);
        rd(20000); chk("default rate", 1000000, v);
        chk("rresp", 0, 32'(r));
        chk("ref div", 40000, pll_ref_div);
    endtask
    // PLL mode: exact rate, multiplier and both clamps
    task automatic t_pll;
        wr(20000, 2500000); rd(20000); chk("rate", 2500000, v);
        chk("pll_mult", 2500, pll_mult);
        wr(20000, 500); rd(20000); chk("low clamp", 1000, v);
        wr(20000, 30000000);
        rd(20000); chk("top", 20000000, v);
    endtask
    // Divider mode: nearest reachable rate and its divisor
    task automatic t_quartz;
        wr(20030, 0); chk("pll off", 0, 32'(pll_enable));
        wr(20000, 3000000);
        rd(20000); chk("div rate", 2500000, v);
        chk("divisor", 8, 32'(quartz_div));
        wr(20000, 20000000);
        rd(20000); chk("quartz", 20000000, v);
    endtask
    // Connector as output with internal clocking, no load then
    task automatic t_connector;
        wr(20030, 1); chk("bresp", 0, 32'(r));
        wr(20110, 1); wr(20120, 1);
        chk("clock out", 1, 32'(clock_out_drive));
        chk("no load", 0, 32'(term_connect));
    endtask
    // External reference turns the connector into an input
    task automatic t_ext_ref;
        wr(20140, ref_hz); chk("ext ref", 1, 32'(ref_external));
        chk("out off", 0, 32'(clock_out_drive));
        chk("load", 1, 32'(term_connect));
        chk("ext ref div", 10000, pll_ref_div);
        wr(20120, 0); chk("high z", 0, 32'(term_connect));
        wr(20000, 25000000);
        rd(20000); chk("ext rate", 20000000, v);
        wr(20140, 200000000);
        rd(20140); chk("ref max", 125000000, v);
        wr(20140, 0); chk("int ref", 0, 32'(ref_external));
    endtask
    // Unmapped indices, channel set and status word
    task automatic t_regs;
        wr(20001, 5); chk("unmapped", 2, 32'(r));
        rd(20001); chk("rd unmapped", 2, 32'(r));
        wr(20200, 3); rd(20200); chk("chan set", 3, v);
        wr(20200, 2); rd(20200); chk("chan kept", 3, v);
        rd(20210); chk("status", 0, v);
        chk("busy", 0, 32'(rate_busy));
    endtask
    task automatic finish_test;
        $display("fails %0d cmp_count %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        repeat (50000) @(posedge aclk);
        fails++;
        finish_test();
    end
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        repeat (3) @(posedge aclk);
        while (rate_busy !== 1'b0) @(posedge aclk);
        t_defaults();
        t_pll();
        t_quartz();
        t_connector();
        t_ext_ref();
        t_regs();
        finish_test();
    end
endmodule
